//--- include/timer2_pkg.sv
package timer2_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam int unsigned    ADDR_W       = 8;
  localparam logic [7:0]     CTRL_OFS     = 8'h00;
  localparam logic [7:0]     CLKCTL_OFS   = 8'h04;
  localparam logic [7:0]     RELOAD_OFS   = 8'h08;
  localparam logic [7:0]     COUNT_OFS    = 8'h0C;
  localparam logic [7:0]     IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0]     IRQ_MASK_OFS = 8'h14;

  // Control register field positions
  localparam int unsigned    HI_FLAG_BIT  = 7;
  localparam int unsigned    LO_FLAG_BIT  = 6;
  localparam int unsigned    LO_IEN_BIT   = 5;
  localparam int unsigned    SPLIT_BIT    = 3;
  localparam int unsigned    RUN_BIT      = 2;
  localparam int unsigned    XCLK_BIT     = 0;
  localparam logic [7:0]     CTRL_WR_MASK = 8'hED;
  localparam logic [7:0]     CTRL_RESET   = 8'h00;

  // Clock control, interrupt status and mask field positions
  localparam int unsigned    CLK_LO_BIT   = 0;
  localparam int unsigned    CLK_HI_BIT   = 1;
  localparam int unsigned    IRQ_HI_BIT   = 0;
  localparam int unsigned    IRQ_LO_BIT   = 1;
  localparam int unsigned    IRQ_W        = 2;

  // Counter constants and reset values
  localparam logic [7:0]     BYTE_ONES    = 8'hFF;
  localparam logic [7:0]     BYTE_ZERO    = 8'h00;
  localparam logic [15:0]    WORD_ZERO    = 16'h0000;
  localparam logic [31:0]    DATA_ZERO    = 32'h0000_0000;

  // Prescaler ratios
  localparam int unsigned    SYS_DIV      = 12;
  localparam int unsigned    EXT_DIV      = 8;

  // AXI responses
  localparam logic [1:0]     RESP_OKAY    = 2'b00;
  localparam logic [1:0]     RESP_SLVERR  = 2'b10;

endpackage : timer2_pkg

//--- design/tick_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

module tick_prescaler #(
  parameter int unsigned SYS_DIV = timer2_pkg::SYS_DIV,
  parameter int unsigned EXT_DIV = timer2_pkg::EXT_DIV
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ext_clk_in,
  input  wire logic ext_select,
  output logic      ext_tick
);

  localparam int unsigned SW = $clog2(SYS_DIV);
  localparam int unsigned EW = $clog2(EXT_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

  logic [SW-1:0] sys_cnt_ff;
  logic [EW-1:0] ext_cnt_ff;
  logic          ext_prev_ff;
  logic          sys_tick_ff;
  logic          ext_tick_ff;

  // Rising edges of the external clock input
  wire ext_edge = ext_clk_in && !ext_prev_ff;
  // [RL13] system clock over twelve
  wire sys_wrap = sys_cnt_ff == SYS_LAST;
  wire ext_wrap = ext_edge && (ext_cnt_ff == EXT_LAST);

  // Both dividers run free so a source change takes effect at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_cnt_ff  <= '0;
      ext_cnt_ff  <= '0;
      ext_prev_ff <= 1'b0;
      sys_tick_ff <= 1'b0;
      ext_tick_ff <= 1'b0;
    end else begin
      sys_cnt_ff  <= sys_wrap ? '0 : SW'(sys_cnt_ff + 1'b1);
      ext_cnt_ff  <= ext_edge ? (ext_wrap ? '0 : EW'(ext_cnt_ff + 1'b1)) : ext_cnt_ff;
      ext_prev_ff <= ext_clk_in;
      sys_tick_ff <= sys_wrap;
      // [RL10] external over eight
      ext_tick_ff <= ext_select ? ext_wrap : sys_wrap;
    end
  end

  assign ext_tick = ext_tick_ff;

  chk_sys_div_period: assert property (@(posedge aclk) disable iff (!aresetn) // [RL13]
    sys_tick_ff |=> !sys_tick_ff ##10 !sys_tick_ff ##1 sys_tick_ff)
    else $error("system clock prescaler period is not twelve");

  chk_ext_div_tick: assert property (@(posedge aclk) disable iff (!aresetn) // [RL10]
    ext_select && ext_edge && (ext_cnt_ff != EXT_LAST) |=> !ext_tick_ff)
    else $error("external prescaler ticked before eighth edge");

endmodule : tick_prescaler

`default_nettype wire

//--- design/timer2_ctrl.sv
// Notes on behaviour
// [RL1] Low byte rolling from all ones to zero sets the low-byte overflow flag.
// [RL2] Low flag raises an interrupt only with low enable and timer interrupts enabled.
// [RL3] Low-byte overflow flag sets in both split and combined modes.
// [RL4] Hardware never clears overflow flags; software clears them by writing zero.
// [RL5] Low-byte interrupt enable: zero disables, one enables low overflow interrupts.
// [RL6] Software should keep low interrupt enable clear in combined 16-bit mode.
// [RL7] Control bits 4 and 1 read zero and ignore writes.
// [RL8] Split bit zero gives one 16-bit counter, one gives two 8-bit counters.
// [RL9] Run bit gates the timer; in split mode only the high byte.
// [RL10] External select one picks external clock input divided by eight.
// [RL11] In split mode the external select applies to both bytes together.
// [RL12] Per-byte clock choice bits pick prescaled source or system clock per byte.
// [RL13] External select zero picks system clock divided by twelve.
// [RL14] Combined counter wrapping all ones to zero sets the high-byte overflow flag.
// [RL15] Each counting unit reloads from its reload value when its flag sets.
`timescale 1ns/10ps
`default_nettype none

module timer2_ctrl #(
  parameter int unsigned ADDR_W = timer2_pkg::ADDR_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_clk_in,
  output logic                   irq
);

  // Address match against a register offset
  function automatic logic at_ofs(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    at_ofs = addr == ADDR_W'(ofs);
  endfunction : at_ofs

  // True for any offset that holds a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    is_mapped = at_ofs(addr, timer2_pkg::CTRL_OFS) || at_ofs(addr, timer2_pkg::CLKCTL_OFS) ||
                at_ofs(addr, timer2_pkg::RELOAD_OFS) || at_ofs(addr, timer2_pkg::COUNT_OFS) ||
                at_ofs(addr, timer2_pkg::IRQ_STAT_OFS) || at_ofs(addr, timer2_pkg::IRQ_MASK_OFS);
  endfunction : is_mapped

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge16

  // Byte increment that stays eight bits wide
  function automatic logic [7:0] inc8(input logic [7:0] val);
    inc8 = 8'(val + 8'h01);
  endfunction : inc8

  logic [ADDR_W-1:0]                aw_addr_ff;
  logic                             aw_held_ff;
  logic [31:0]                      w_data_ff;
  logic [3:0]                       w_strb_ff;
  logic                             w_held_ff;
  logic                             bvalid_ff;
  logic [1:0]                       bresp_ff;
  logic                             rvalid_ff;
  logic [31:0]                      rdata_ff;
  logic [1:0]                       rresp_ff;
  logic [7:0]                       ctrl_ff;
  logic [1:0]                       clk_choice_ff;
  logic [15:0]                      reload_ff;
  logic [7:0]                       cnt_lo_ff;
  logic [7:0]                       cnt_hi_ff;
  logic [timer2_pkg::IRQ_W-1:0]     irq_stat_ff;
  logic [timer2_pkg::IRQ_W-1:0]     irq_mask_ff;
  logic                             ext_tick;

  // Bus handshakes: one write and one read at a time
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  wire   wr_fire       = aw_held_ff && w_held_ff;
  wire   rd_fire       = s_axi_arvalid && s_axi_arready;

  // Write decode, lane 0 carries the byte-wide registers
  wire wr_ctrl   = wr_fire && at_ofs(aw_addr_ff, timer2_pkg::CTRL_OFS) && w_strb_ff[0];
  wire wr_clkctl = wr_fire && at_ofs(aw_addr_ff, timer2_pkg::CLKCTL_OFS) && w_strb_ff[0];
  wire wr_reload = wr_fire && at_ofs(aw_addr_ff, timer2_pkg::RELOAD_OFS);
  wire wr_count  = wr_fire && at_ofs(aw_addr_ff, timer2_pkg::COUNT_OFS) && (|w_strb_ff[1:0]);
  wire wr_mask   = wr_fire && at_ofs(aw_addr_ff, timer2_pkg::IRQ_MASK_OFS) && w_strb_ff[0];
  wire rd_stat   = rd_fire && at_ofs(s_axi_araddr, timer2_pkg::IRQ_STAT_OFS);

  // Control fields
  wire split   = ctrl_ff[timer2_pkg::SPLIT_BIT];
  wire run     = ctrl_ff[timer2_pkg::RUN_BIT];
  wire lo_ien  = ctrl_ff[timer2_pkg::LO_IEN_BIT];
  wire ext_sel = ctrl_ff[timer2_pkg::XCLK_BIT];

  // [RL12] per-byte clock choice
  wire lo_tick = clk_choice_ff[timer2_pkg::CLK_LO_BIT] || ext_tick;
  wire hi_tick = clk_choice_ff[timer2_pkg::CLK_HI_BIT] || ext_tick;

  // [RL9] run gating per mode
  wire lo_step = split ? lo_tick : (run && lo_tick);
  wire hi_step = run && hi_tick;

  // [RL1] low byte rollover
  wire lo_full   = cnt_lo_ff == timer2_pkg::BYTE_ONES;
  wire hi_full   = cnt_hi_ff == timer2_pkg::BYTE_ONES;
  wire lo_evt    = lo_step && lo_full;
  // [RL14] combined counter wrap
  wire word_wrap = !split && lo_evt && hi_full;
  // [RL8] structure follows split bit
  wire hi_evt    = split ? (hi_step && hi_full) : word_wrap;

  // [RL15] reload on each split byte overflow and on the 16-bit wrap; combined low byte otherwise rolls to zero
  wire [7:0] lo_next = !lo_step ? cnt_lo_ff :
                       !lo_full ? inc8(cnt_lo_ff) :
                       (split || hi_full) ? reload_ff[7:0] : timer2_pkg::BYTE_ZERO;
  wire       hi_adv  = split ? hi_step : lo_evt;
  wire [7:0] hi_next = !hi_adv ? cnt_hi_ff : hi_full ? reload_ff[15:8] : inc8(cnt_hi_ff);
  wire [15:0] nxt_cnt = wr_count ? merge16({cnt_hi_ff, cnt_lo_ff}, w_data_ff, w_strb_ff)
                                 : {hi_next, lo_next};

  // [RL3] low flag in every mode
  wire [7:0] flag_set = (8'(lo_evt) << timer2_pkg::LO_FLAG_BIT) |
                        (8'(hi_evt) << timer2_pkg::HI_FLAG_BIT);
  // [RL7] unused bits held at zero
  wire [7:0] ctrl_base = wr_ctrl ? (w_data_ff[7:0] & timer2_pkg::CTRL_WR_MASK) : ctrl_ff;
  // [RL4] flags set by hardware win over a clearing write
  wire [7:0] nxt_ctrl  = ctrl_base | flag_set;

  // [RL5] low events reach the status only while enabled
  wire [timer2_pkg::IRQ_W-1:0] irq_evt =
    (timer2_pkg::IRQ_W'(lo_evt && lo_ien) << timer2_pkg::IRQ_LO_BIT) |
    (timer2_pkg::IRQ_W'(hi_evt) << timer2_pkg::IRQ_HI_BIT);
  wire [timer2_pkg::IRQ_W-1:0] nxt_irq_stat = irq_evt | (rd_stat ? '0 : irq_stat_ff);

  // Read data selection
  wire [31:0] rd_word =
    at_ofs(s_axi_araddr, timer2_pkg::CTRL_OFS)     ? 32'(ctrl_ff) :
    at_ofs(s_axi_araddr, timer2_pkg::CLKCTL_OFS)   ? 32'(clk_choice_ff) :
    at_ofs(s_axi_araddr, timer2_pkg::RELOAD_OFS)   ? 32'(reload_ff) :
    at_ofs(s_axi_araddr, timer2_pkg::COUNT_OFS)    ? 32'({cnt_hi_ff, cnt_lo_ff}) :
    at_ofs(s_axi_araddr, timer2_pkg::IRQ_STAT_OFS) ? 32'(irq_stat_ff) :
    at_ofs(s_axi_araddr, timer2_pkg::IRQ_MASK_OFS) ? 32'(irq_mask_ff) : timer2_pkg::DATA_ZERO;

  // [RL11] one prescaled source for both bytes
  tick_prescaler #(
    .SYS_DIV (timer2_pkg::SYS_DIV),
    .EXT_DIV (timer2_pkg::EXT_DIV)
  ) u_prescaler (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ext_clk_in (ext_clk_in),
    .ext_select (ext_sel),
    .ext_tick   (ext_tick)
  );

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_ff <= '0;
      aw_held_ff <= 1'b0;
      w_data_ff  <= timer2_pkg::DATA_ZERO;
      w_strb_ff  <= '0;
      w_held_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= timer2_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        w_held_ff <= 1'b1;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= is_mapped(aw_addr_ff) ? timer2_pkg::RESP_OKAY : timer2_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= timer2_pkg::DATA_ZERO;
      rresp_ff  <= timer2_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= is_mapped(s_axi_araddr) ? timer2_pkg::RESP_OKAY : timer2_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff       <= timer2_pkg::CTRL_RESET;
      clk_choice_ff <= '0;
      reload_ff     <= timer2_pkg::WORD_ZERO;
      irq_mask_ff   <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      if (wr_clkctl) begin
        clk_choice_ff <= w_data_ff[1:0];
      end
      if (wr_reload) begin
        reload_ff <= merge16(reload_ff, w_data_ff, w_strb_ff);
      end
      if (wr_mask) begin
        irq_mask_ff <= w_data_ff[timer2_pkg::IRQ_W-1:0];
      end
    end
  end

  // Counter and sticky interrupt status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_lo_ff   <= timer2_pkg::BYTE_ZERO;
      cnt_hi_ff   <= timer2_pkg::BYTE_ZERO;
      irq_stat_ff <= '0;
    end else begin
      cnt_lo_ff   <= nxt_cnt[7:0];
      cnt_hi_ff   <= nxt_cnt[15:8];
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // [RL2] interrupt needs enabled status bit
  assign irq           = |(irq_stat_ff & irq_mask_ff);
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  chk_lo_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
    lo_step && cnt_lo_ff == timer2_pkg::BYTE_ONES |=> ctrl_ff[timer2_pkg::LO_FLAG_BIT])
    else $error("low overflow flag not set on rollover");

  chk_irq_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn) // [RL2]
    $rose(irq_stat_ff[timer2_pkg::IRQ_LO_BIT]) |-> $past(lo_evt && lo_ien))
    else $error("low interrupt status set without enable");

  chk_split_lo_reload: assert property (@(posedge aclk) disable iff (!aresetn) // [RL3]
    split && lo_tick && lo_full && !wr_count && !wr_ctrl
    |=> ctrl_ff[timer2_pkg::LO_FLAG_BIT] && cnt_lo_ff == $past(reload_ff[7:0]))
    else $error("split low byte did not flag and reload");

  chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
    ctrl_ff[timer2_pkg::LO_FLAG_BIT] && !wr_ctrl |=> ctrl_ff[timer2_pkg::LO_FLAG_BIT])
    else $error("low overflow flag cleared without software");

  chk_lo_ien_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [RL5]
    lo_evt && !lo_ien && !irq_stat_ff[timer2_pkg::IRQ_LO_BIT]
    |=> !irq_stat_ff[timer2_pkg::IRQ_LO_BIT])
    else $error("disabled low overflow reached interrupt status");

  chk_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RL7]
    wr_ctrl |=> (ctrl_ff & ~timer2_pkg::CTRL_WR_MASK) == timer2_pkg::BYTE_ZERO)
    else $error("unused control bits not zero");

  chk_word_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // [RL14]
    !split && run && lo_tick && lo_full && hi_full && !wr_count && !wr_ctrl
    |=> ctrl_ff[timer2_pkg::HI_FLAG_BIT] && {cnt_hi_ff, cnt_lo_ff} == $past(reload_ff))
    else $error("16-bit wrap did not flag and reload");

  chk_run_stops_high: assert property (@(posedge aclk) disable iff (!aresetn) // [RL9]
    !run && !wr_count |=> $stable(cnt_hi_ff))
    else $error("high byte moved while stopped");

  chk_sys_choice_count: assert property (@(posedge aclk) disable iff (!aresetn) // [RL12]
    split && clk_choice_ff[timer2_pkg::CLK_LO_BIT] && !lo_full && !wr_count
    |=> cnt_lo_ff == inc8($past(cnt_lo_ff)))
    else $error("low byte on system clock did not advance");

endmodule : timer2_ctrl

`default_nettype wire

//--- test/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        ext_clk_in;
  logic        irq;
  int          num_errors;
  int          num_checks;
  logic [31:0] v;
  logic [1:0]  r;

  timer2_ctrl u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_clk_in(ext_clk_in), .irq(irq)
  );

  // Clock at 8 ns period
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // External clock toggles every two cycles
  initial begin
    ext_clk_in = 1'b0;
    forever begin
      repeat (2) @(posedge aclk);
      ext_clk_in <= ~ext_clk_in;
    end
  end

  // Prints counts and verdict
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic check_in(input string name, input logic [31:0] seen, input int lo, input int hi);
    check(name, {31'h0000_0000, (seen >= lo && seen <= hi)}, 32'h0000_0001);
  endtask : check_in

  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // AXI4-Lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d    = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_cyc

  // Watchdog cuts a hang short
  initial begin
    wait_cyc(20000);
    num_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    num_errors = 0;
    num_checks = 0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    wait_cyc(10);
    aresetn <= 1'b1;
    // Reset value and unmapped address
    rd(timer2_pkg::CTRL_OFS, v, r);
    check("ctrl reset", v, 32'h0000_0000);
    rd(8'h40, v, r);
    check("unmapped rresp", {30'h0, r}, {30'h0, timer2_pkg::RESP_SLVERR});
    check("unmapped rdata", v, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF, r);
    check("unmapped bresp", {30'h0, r}, {30'h0, timer2_pkg::RESP_SLVERR});
    wr(timer2_pkg::CTRL_OFS, 32'h0000_00FF, r);
    rd(timer2_pkg::CTRL_OFS, v, r);
    check("ctrl unused bits", v, 32'h0000_00ED);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0000, r);
    rd(timer2_pkg::CTRL_OFS, v, r);
    check("ctrl flags cleared", v, 32'h0000_0000);
    // Split mode low byte overflow with high byte stopped
    wr(timer2_pkg::CLKCTL_OFS, 32'h0000_0001, r);
    wr(timer2_pkg::RELOAD_OFS, 32'h0000_00F0, r);
    wr(timer2_pkg::COUNT_OFS, 32'h0000_0000, r);
    wr(timer2_pkg::IRQ_MASK_OFS, 32'h0000_0002, r);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0008, r);
    wait_cyc(300);
    rd(timer2_pkg::CTRL_OFS, v, r);
    check("split low flag", v, 32'h0000_0048);
    check("irq low disabled", {31'h0, irq}, 32'h0000_0000);
    rd(timer2_pkg::IRQ_STAT_OFS, v, r);
    check("stat low disabled", v, 32'h0000_0000);
    rd(timer2_pkg::COUNT_OFS, v, r);
    check("split high held", {24'h0, v[15:8]}, 32'h0000_0000);
    check_in("split low reload", {24'h0, v[7:0]}, 8'hF0, 8'hFF);
    // Low interrupt with enable and mask, then combined 16-bit wrap, status read clear and system clock divide
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0028, r);
    wait_cyc(40);
    check("irq low enabled", {31'h0, irq}, 32'h0000_0001);
    rd(timer2_pkg::IRQ_STAT_OFS, v, r);
    check("stat low bit", v & 32'h0000_0002, 32'h0000_0002);
    wr(timer2_pkg::IRQ_MASK_OFS, 32'h0000_0000, r);
    @(posedge aclk);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0000, r);
    rd(timer2_pkg::IRQ_STAT_OFS, v, r);
    wr(timer2_pkg::RELOAD_OFS, 32'h0000_ABCD, r);
    wr(timer2_pkg::COUNT_OFS, 32'h0000_FFF0, r);
    wr(timer2_pkg::IRQ_MASK_OFS, 32'h0000_0001, r);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0004, r);
    wait_cyc(40);
    check("irq high", {31'h0, irq}, 32'h0000_0001);
    rd(timer2_pkg::CTRL_OFS, v, r);
    check("wide flags", v, 32'h0000_00C4);
    rd(timer2_pkg::COUNT_OFS, v, r);
    check_in("wide reload", {16'h0, v[15:0]}, 16'hABCD, 16'hABFF);
    rd(timer2_pkg::IRQ_STAT_OFS, v, r);
    check("stat high only", v, 32'h0000_0001);
    check("irq cleared by read", {31'h0, irq}, 32'h0000_0000);
    wait_cyc(200);
    rd(timer2_pkg::CTRL_OFS, v, r);
    check("high flag kept", v & 32'h0000_0080, 32'h0000_0080);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0000, r);
    wr(timer2_pkg::CLKCTL_OFS, 32'h0000_0000, r);
    wr(timer2_pkg::COUNT_OFS, 32'h0000_0000, r);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0004, r);
    wait_cyc(120);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0000, r);
    rd(timer2_pkg::COUNT_OFS, v, r);
    check_in("sys div count", v, 9, 12);
    // External clock divided by eight, source switched while stopped, then split high byte on system clock
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0001, r);
    wr(timer2_pkg::COUNT_OFS, 32'h0000_0000, r);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0005, r);
    wait_cyc(160);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0001, r);
    rd(timer2_pkg::COUNT_OFS, v, r);
    check_in("ext div count", v, 4, 6);
    wr(timer2_pkg::CLKCTL_OFS, 32'h0000_0001, r);
    wr(timer2_pkg::RELOAD_OFS, 32'h0000_0000, r);
    wr(timer2_pkg::COUNT_OFS, 32'h0000_0000, r);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_000D, r);
    wait_cyc(160);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0009, r);
    rd(timer2_pkg::COUNT_OFS, v, r);
    check_in("split high ext", {24'h0, v[15:8]}, 4, 6);
    wr(timer2_pkg::CLKCTL_OFS, 32'h0000_0002, r);
    wr(timer2_pkg::COUNT_OFS, 32'h0000_0000, r);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_000C, r);
    wait_cyc(100);
    wr(timer2_pkg::CTRL_OFS, 32'h0000_0008, r);
    rd(timer2_pkg::COUNT_OFS, v, r);
    check_in("split high sys", {24'h0, v[15:8]}, 8'h60, 8'h70);
    complete_run();
  end
endmodule : tb

`default_nettype wire
